// File: pkg/pfw_pkg.sv
package pfw_pkg;

    // configuration dword offsets
    localparam logic [7:0]  PFW_OFF_BASE_LIMIT = 8'h24;
    localparam logic [7:0]  PFW_OFF_BASE_HI    = 8'h28;
    localparam logic [7:0]  PFW_OFF_LIMIT_HI   = 8'h2C;

    // field positions inside the base/limit dword
    localparam int          PFW_BASE_LSB       = 4;
    localparam int          PFW_LIMIT_LSB      = 20;
    localparam int          PFW_CAP_LSB        = 0;
    localparam int          PFW_LIMIT_CAP_LSB  = 16;

    // values after reset and fixed fields
    localparam logic [11:0] PFW_BASE_RST       = 12'h000;
    localparam logic [11:0] PFW_LIMIT_RST      = 12'h000;
    localparam logic [31:0] PFW_HI_RST         = 32'h0000_0000;
    localparam logic [3:0]  PFW_CAP_64         = 4'h1;
    localparam logic [19:0] PFW_LOW_BASE       = 20'h0_0000;
    localparam logic [19:0] PFW_LOW_LIMIT      = 20'hF_FFFF;
    localparam logic [31:0] PFW_ZERO32         = 32'h0000_0000;

    // legacy display decode
    localparam logic [31:0] PFW_VGA_MEM_LO     = 32'h000A_0000;
    localparam logic [31:0] PFW_VGA_MEM_HI     = 32'h000B_FFFF;
    localparam logic [9:0]  PFW_VGA_IO_A_LO    = 10'h3B0;
    localparam logic [9:0]  PFW_VGA_IO_A_HI    = 10'h3BB;
    localparam logic [9:0]  PFW_VGA_IO_B_LO    = 10'h3C0;
    localparam logic [9:0]  PFW_VGA_IO_B_HI    = 10'h3DF;
    localparam logic [9:0]  PFW_PAL_MASK       = 10'h3C6;
    localparam logic [9:0]  PFW_PAL_WADDR      = 10'h3C8;
    localparam logic [9:0]  PFW_PAL_DATA       = 10'h3C9;

    typedef enum logic [0:0] {
        PFW_IDLE,
        PFW_WAIT_HI
    } pfw_state_t;

    // address phase seen on one of the two buses
    typedef struct packed {
        logic        strobe;
        logic        side;     // 0 primary, 1 secondary
        logic        dac;
        logic        io;
        logic        wr;
        logic [3:0]  be;
        logic [31:0] ad;
    } pfw_req_t;

    // configuration access
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [7:0]  addr;
        logic [3:0]  be;
        logic [31:0] wdata;
    } pfw_cfg_t;

    // decode answer
    typedef struct packed {
        logic        valid;
        logic        claim;
        logic        down;
        logic        in_win;
        logic        win_off;
        logic        prefetch;
        logic        single_phase;
        logic        snoop;
        logic [3:0]  be;
    } pfw_dec_t;

    // byte-enable merge of a configuration write
    function automatic logic [31:0] pfw_merge(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0]  be);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++)
        begin
            if (be[i])
            begin
                r[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // legacy display I/O alias: bits 15:10 ignored, 31:16 zero
    function automatic logic pfw_io_alias_ok(input logic [31:0] a);
        return a[31:16] == 16'h0000;
    endfunction

endpackage

// File: core/pfw_decode.sv
`timescale 1ns/1ps

// What this block does
// - window aligned and sized in 1 MB
// - top twelve bits give address 31:20
// - low nibble of base/limit reads 1h
// - base padded zeros, limit padded ones
// - reset window covers lowest 1 MB
// - base above limit, 64-bit, disables window
// - dual cycle: low word first, high second
// - both highs zero: primary DAC ignored, secondary up
// - both highs nonzero: primary SAC ignored
// - above 4 GB: in-window down, out-window up
// - straddle: SAC compared against lower base
// - straddle: DAC compared against upper limit
// - display mode forwards frame buffer, display I/O
// - frame buffer reads: one phase, byte enables
// - display I/O ranges, 1 KB alias below 64 KB
// - no extra decode of display firmware region
// - palette snoop claims palette writes downstream
// - both bits set acts as display mode
// - memory enable downstream, master enable upstream
// - primary in-window down, secondary in-window ignored
// - single cycle uses zero upper address word
module pfw_decode
    import pfw_pkg::*;
(
    input  wire logic        i_core_clk,
    input  wire logic        i_rst,
    input  wire pfw_cfg_t    i_cfg,
    output logic [31:0]      o_cfg_rdata,
    input  wire logic        i_mem_enable,
    input  wire logic        i_master_enable,
    input  wire logic        i_io_enable,
    input  wire logic        i_vga_mode,
    input  wire logic        i_vga_snoop,
    input  wire logic        i_mmio_hit,
    input  wire pfw_req_t    i_req,
    output pfw_dec_t         o_dec,
    output logic             o_wait_high
);

    typedef struct packed {
        pfw_state_t  st;
        pfw_req_t    pend;
        logic [11:0] base;
        logic [11:0] limit;
        logic [31:0] base_hi;
        logic [31:0] limit_hi;
        logic [31:0] rdata;
        pfw_dec_t    dec;
    } pfw_regs_t;

    // the whole state bank and its next value
    pfw_regs_t   r;
    pfw_regs_t   next_r;

    // decode intermediates, all combinational
    logic        dec_go;
    pfw_req_t    cur;
    logic [31:0] addr_hi;
    logic [63:0] addr64;
    logic [63:0] base64;
    logic [63:0] limit64;
    logic        win_off;
    logic        in_win;
    logic        vga_mem;
    logic        vga_io;
    logic        pal_io;
    logic        ord_mmio;
    logic        down_mem;
    logic        up_mem;
    logic        down_io;
    logic [31:0] dw_base_limit;
    logic [31:0] merged_bl;

    // inclusive 10-bit I/O span, shared by both display ranges
    function automatic logic io_span(input logic [9:0] a,
                                     input logic [9:0] lo,
                                     input logic [9:0] hi);
        return (a >= lo) && (a <= hi);
    endfunction

    // the three palette ports, low ten bits only after aliasing
    function automatic logic pal_hit(input logic [9:0] a);
        return (a == PFW_PAL_MASK) || (a == PFW_PAL_WADDR) || (a == PFW_PAL_DATA);
    endfunction

    // extended window bounds, 1 MB granular
    always_comb
    begin
        base64  = {r.base_hi, r.base, PFW_LOW_BASE};
        limit64 = {r.limit_hi, r.limit, PFW_LOW_LIMIT};
        win_off = base64 > limit64;
    end

    // the dword at the base/limit offset: capability nibble is fixed
    always_comb
    begin
        dw_base_limit = PFW_ZERO32;
        dw_base_limit[PFW_BASE_LSB +: 12]       = r.base;
        dw_base_limit[PFW_LIMIT_LSB +: 12]      = r.limit;
        dw_base_limit[PFW_CAP_LSB +: 4]         = PFW_CAP_64;
        dw_base_limit[PFW_LIMIT_CAP_LSB +: 4]   = PFW_CAP_64;
        // a write merges over the read view, so the fixed nibbles stay put
        merged_bl = pfw_merge(dw_base_limit, i_cfg.wdata, i_cfg.be);
    end

    // pick the address that is being decoded this cycle
    always_comb
    begin
        dec_go  = 1'b0;
        cur     = i_req;
        addr_hi = PFW_ZERO32;
        case (r.st)
            PFW_IDLE:
            begin
                dec_go = i_req.strobe && !i_req.dac;
            end
            PFW_WAIT_HI:
            begin
                // second phase carries the high word only
                dec_go  = i_req.strobe;
                cur     = r.pend;
                addr_hi = i_req.ad;
            end
            default:
            begin
                dec_go = 1'b0;
            end
        endcase
        addr64 = {addr_hi, cur.ad};
    end

    // window hit and the legacy display ranges
    always_comb
    begin
        // the one inclusive compare covers all three placements: a
        // below-4 GB window never holds a dual address, an above-4 GB
        // window never holds a single one, and a straddling window
        // reduces to base-only for SAC and limit-only for DAC
        in_win = !win_off && !cur.io
                 && (addr64 >= base64)
                 && (addr64 <= limit64);
        // frame buffer only; firmware region above it is left alone
        vga_mem = i_vga_mode && !cur.io && !cur.dac
                  && (cur.ad >= PFW_VGA_MEM_LO)
                  && (cur.ad <= PFW_VGA_MEM_HI);
        vga_io  = i_vga_mode && cur.io && pfw_io_alias_ok(cur.ad)
                  && (io_span(cur.ad[9:0], PFW_VGA_IO_A_LO, PFW_VGA_IO_A_HI)
                   || io_span(cur.ad[9:0], PFW_VGA_IO_B_LO, PFW_VGA_IO_B_HI));
        // snoop is shadowed when display mode already covers it
        pal_io  = i_vga_snoop && !i_vga_mode && cur.io && cur.wr
                  && pfw_io_alias_ok(cur.ad)
                  && pal_hit(cur.ad[9:0]);
        // non-prefetchable window is 32-bit only
        ord_mmio = i_mmio_hit && !cur.io && !cur.dac;
    end

    // forwarding direction per bus
    always_comb
    begin
        down_mem = 1'b0;
        up_mem   = 1'b0;
        down_io  = 1'b0;
        if (!cur.side)
        begin
            // primary: claim in-window, display and ordinary windows
            down_mem = i_mem_enable
                       && (in_win || vga_mem || ord_mmio);
            down_io  = i_io_enable && (vga_io || pal_io);
        end
        else
        begin
            // secondary: all memory outside the downstream ranges goes up, I/O never does;
            // a primary-side zero-high DAC is illegal, so none is special
            up_mem   = i_master_enable && !cur.io
                       && !in_win && !vga_mem && !ord_mmio;
        end
    end

    // next state: configuration, phase tracking, registered answer
    always_comb
    begin
        next_r           = r;
        next_r.dec.valid = 1'b0;
        next_r.dec.snoop = 1'b0;
        next_r.dec.claim = 1'b0;

        // configuration writes; only the 12-bit fields and the two high dwords are writable
        if (i_cfg.wr)
        begin
            case (i_cfg.addr)
                PFW_OFF_BASE_LIMIT:
                begin
                    next_r.base  = merged_bl[PFW_BASE_LSB +: 12];
                    next_r.limit = merged_bl[PFW_LIMIT_LSB +: 12];
                end
                PFW_OFF_BASE_HI:
                begin
                    next_r.base_hi = pfw_merge(r.base_hi, i_cfg.wdata, i_cfg.be);
                end
                PFW_OFF_LIMIT_HI:
                begin
                    next_r.limit_hi = pfw_merge(r.limit_hi, i_cfg.wdata, i_cfg.be);
                end
                default:
                begin
                    next_r.base = r.base;
                end
            endcase
        end

        // configuration reads; unmapped offsets answer zero
        if (i_cfg.rd)
        begin
            case (i_cfg.addr)
                PFW_OFF_BASE_LIMIT:
                begin
                    next_r.rdata = dw_base_limit;
                end
                PFW_OFF_BASE_HI:
                begin
                    next_r.rdata = r.base_hi;
                end
                PFW_OFF_LIMIT_HI:
                begin
                    next_r.rdata = r.limit_hi;
                end
                default:
                begin
                    next_r.rdata = PFW_ZERO32;
                end
            endcase
        end

        // address phase tracking
        case (r.st)
            PFW_IDLE:
            begin
                if (i_req.strobe && i_req.dac)
                begin
                    next_r.pend = i_req;
                    next_r.st   = PFW_WAIT_HI;
                end
            end
            PFW_WAIT_HI:
            begin
                if (i_req.strobe)
                begin
                    next_r.st = PFW_IDLE;
                end
            end
            default:
            begin
                next_r.st = PFW_IDLE;
            end
        endcase

        // decode answer, one cycle after the last address phase
        if (dec_go)
        begin
            next_r.dec.valid        = 1'b1;
            next_r.dec.claim        = down_mem || up_mem || down_io;
            next_r.dec.down         = !cur.side;
            next_r.dec.in_win       = in_win;
            next_r.dec.win_off      = win_off;
            next_r.dec.prefetch     = in_win && !cur.wr && !vga_mem && down_mem;
            // side-effect risk: frame buffer reads never prefetch
            next_r.dec.single_phase = vga_mem && !cur.wr && down_mem;
            next_r.dec.snoop        = pal_io && down_io;
            next_r.dec.be           = cur.be;
        end
    end

    // one register bank for all state
    always_ff @(posedge i_core_clk)
    begin
        if (i_rst)
        begin
            // clear everything, then lay down the reset window
            r          <= '0;
            r.st       <= PFW_IDLE;
            r.base     <= PFW_BASE_RST;
            r.limit    <= PFW_LIMIT_RST;
            r.base_hi  <= PFW_HI_RST;
            r.limit_hi <= PFW_HI_RST;
        end
        else
        begin
            r <= next_r;
        end
    end

    // outputs straight from the register bank
    assign o_cfg_rdata = r.rdata;
    assign o_dec       = r.dec;
    assign o_wait_high = (r.st == PFW_WAIT_HI);  // handshake level

endmodule // pfw_decode

// File: sim/pfw_decode_asserts.sv
`timescale 1ns/1ps

module pfw_decode_asserts
    import pfw_pkg::*;
(
    input  wire logic        i_core_clk,
    input  wire logic        i_rst,
    input  wire pfw_cfg_t    i_cfg,
    input  wire logic [31:0] o_cfg_rdata,
    input  wire logic        i_mem_enable,
    input  wire logic        i_master_enable,
    input  wire logic        i_vga_mode,
    input  wire pfw_req_t    i_req,
    input  wire pfw_dec_t    o_dec,
    input  wire logic        o_wait_high
);
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_rst);

    // address phases as seen from the idle or waiting state
    sequence s_sac;
        i_req.strobe && !i_req.dac && !o_wait_high;
    endsequence
    sequence s_dac_lo;
        i_req.strobe && i_req.dac && !o_wait_high;
    endsequence
    sequence s_dac_hi;
        i_req.strobe && o_wait_high;
    endsequence

    a_dac_lo_wait: assert property (s_dac_lo |=> o_wait_high && !o_dec.valid)
        else $error("dual cycle answered before its high word");
    a_dac_hi_done: assert property (s_dac_hi |=> o_dec.valid && !o_wait_high)
        else $error("dual cycle high word not decoded");
    a_sac_answer: assert property (s_sac |=> o_dec.valid && o_dec.be == $past(i_req.be))
        else $error("single cycle not answered with its byte enables");
    a_sec_io_off: assert property (s_sac ##0 (i_req.side && i_req.io) |=> !o_dec.claim)
        else $error("secondary io claimed");
    a_down_gated: assert property (o_dec.valid && o_dec.claim && o_dec.down && !$past(i_req.io)
        |-> $past(i_mem_enable))
        else $error("downstream memory claim without memory enable");
    a_up_gated: assert property (o_dec.valid && o_dec.claim && !o_dec.down
        |-> $past(i_master_enable))
        else $error("upstream claim without master enable");
    a_one_phase: assert property (o_dec.valid && o_dec.single_phase
        |-> o_dec.claim && o_dec.down)
        else $error("single phase on a transfer not sent down");
    a_snoop_claim: assert property (o_dec.valid && o_dec.snoop
        |-> o_dec.claim && o_dec.down && !$past(i_vga_mode))
        else $error("palette snoop with display mode or without claim");
    a_off_no_hit: assert property (o_dec.valid && o_dec.win_off |-> !o_dec.in_win)
        else $error("window hit while window off");
    a_cap_nibble: assert property (i_cfg.rd && i_cfg.addr == PFW_OFF_BASE_LIMIT
        |=> o_cfg_rdata[3:0] == PFW_CAP_64 && o_cfg_rdata[19:16] == PFW_CAP_64)
        else $error("capability nibbles wrong");
endmodule // pfw_decode_asserts

bind pfw_decode pfw_decode_asserts i_chk (.i_core_clk, .i_rst, .i_cfg, .o_cfg_rdata,
    .i_mem_enable, .i_master_enable, .i_vga_mode, .i_req, .o_dec, .o_wait_high);

// File: sim/pfw_bus_agent.sv
`timescale 1ns/1ps

// initiator on either bus: one address phase, two for a dual cycle
module pfw_bus_agent
    import pfw_pkg::*;
(
    input  wire logic i_core_clk,
    output pfw_req_t  o_req
);
    initial o_req = '0;

    // dual cycle only when the high word is nonzero
    task automatic issue(input logic [2:0] k, input logic [3:0] be, input logic [63:0] a);
        @(posedge i_core_clk);
        o_req.strobe <= 1'b1;
        o_req.side   <= k[2];
        o_req.io     <= k[1];
        o_req.wr     <= k[0];
        o_req.be     <= be;
        o_req.dac    <= (a[63:32] != 32'h0000_0000);
        o_req.ad     <= a[31:0];
        if (a[63:32] != 32'h0000_0000)
        begin
            @(posedge i_core_clk);
            o_req.ad <= a[63:32];
        end
        @(posedge i_core_clk);
        // released address lines carry junk, not the old address
        o_req.strobe <= 1'b0;
        o_req.ad     <= ~o_req.ad;
    endtask
endmodule // pfw_bus_agent

// File: sim/tb.sv
`timescale 1ns/1ps

module tb;
    import pfw_pkg::*;

    logic        i_core_clk;
    logic        i_rst;
    pfw_cfg_t    i_cfg;
    logic [31:0] o_cfg_rdata;
    logic        mem_en;
    logic        mst_en;
    logic        io_en;
    logic        vga;
    logic        snp;
    logic        mmio;
    pfw_req_t    req;
    pfw_dec_t    dec;
    logic [63:0] pal [3] = '{64'h0000_03C6, 64'h0000_07C8, 64'h0000_FFC9};
    int          err_count = 0;
    int          compares = 0;
    int          cycles = 0;

    pfw_decode i_dut (.i_core_clk, .i_rst, .i_cfg, .o_cfg_rdata, .i_mem_enable(mem_en),
        .i_master_enable(mst_en), .i_io_enable(io_en), .i_vga_mode(vga), .i_vga_snoop(snp),
        .i_mmio_hit(mmio), .i_req(req), .o_dec(dec), .o_wait_high());
    pfw_bus_agent i_agent (.i_core_clk, .o_req(req));

    initial
    begin
        i_core_clk = 1'b0;
        forever #10 i_core_clk = ~i_core_clk;
    end

    // hang guard, far above the fewer than two hundred cycles the run needs
    always @(posedge i_core_clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 4000)
        begin
            err_count++;
            stop_test();
        end
    end

    task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
        compares++;
        if (seen !== exp)
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        if (seen !== exp)
            err_count++;
    endtask

    task automatic stop_test();
        $display("compares %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic cfg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_core_clk);
        i_cfg <= '{wr: 1'b1, rd: 1'b0, addr: a, be: 4'hF, wdata: d};
        @(posedge i_core_clk);
        i_cfg.wr <= 1'b0;
    endtask

    task automatic cfg_rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge i_core_clk);
        i_cfg <= '{wr: 1'b0, rd: 1'b1, addr: a, be: 4'hF, wdata: 32'h0000_0000};
        @(posedge i_core_clk);
        i_cfg.rd <= 1'b0;
        // read data launched at the read edge, taken at the next one
        @(posedge i_core_clk);
        chk("cfg read", o_cfg_rdata, exp);
    endtask

    // k is {secondary, io, write}; direction always follows the issuing bus
    task automatic dq(input logic [2:0] k, input logic [63:0] a, input logic c);
        i_agent.issue(k, 4'h6, a);
        // answer pulse launched at the last address edge stands until the next one
        @(posedge i_core_clk);
        chk("decode", {dec.valid, dec.claim, dec.down, dec.be}, {1'b1, c, ~k[2], 4'h6});
    endtask

    initial
    begin
        i_rst = 1'b1;
        i_cfg = '0;
        {mem_en, mst_en, io_en, vga, snp, mmio} = 6'h00;
        repeat (20) @(posedge i_core_clk);
        i_rst <= 1'b0;
        cfg_rd(PFW_OFF_BASE_LIMIT, 32'h0001_0001);
        cfg_rd(PFW_OFF_BASE_HI, 32'h0000_0000);
        cfg_rd(PFW_OFF_LIMIT_HI, 32'h0000_0000);
        cfg_rd(8'h30, 32'h0000_0000);
        mem_en <= 1'b1;
        mst_en <= 1'b1;
        dq(3'b001, 64'h000F_FFFF, 1'b1);
        dq(3'b001, 64'h0010_0000, 1'b0);
        $display("test reset done");
        // window 1 MB..4 MB; nibble writes must not stick
        cfg_wr(PFW_OFF_BASE_LIMIT, 32'h003F_001F);
        cfg_rd(PFW_OFF_BASE_LIMIT, 32'h0031_0011);
        dq(3'b001, 64'h000F_FFFF, 1'b0);
        dq(3'b001, 64'h0010_0000, 1'b1);
        dq(3'b000, 64'h003F_FFFF, 1'b1);
        dq(3'b001, 64'h0040_0000, 1'b0);
        dq(3'b101, 64'h0020_0000, 1'b0);
        dq(3'b101, 64'h0050_0000, 1'b1);
        mst_en <= 1'b0;
        dq(3'b101, 64'h0050_0000, 1'b0);
        mem_en <= 1'b0;
        mst_en <= 1'b1;
        dq(3'b001, 64'h0020_0000, 1'b0);
        mem_en <= 1'b1;
        $display("test window done");
        dq(3'b001, 64'h0000_0001_0020_0000, 1'b0);
        dq(3'b101, 64'h0000_0001_0020_0000, 1'b1);
        cfg_wr(PFW_OFF_BASE_HI, 32'h0000_0001);
        cfg_wr(PFW_OFF_LIMIT_HI, 32'h0000_0001);
        dq(3'b001, 64'h0020_0000, 1'b0);
        dq(3'b101, 64'h0020_0000, 1'b1);
        // ordinary-window hit: primary claims, secondary stays quiet
        mmio <= 1'b1;
        dq(3'b001, 64'h0020_0000, 1'b1);
        dq(3'b101, 64'h0020_0000, 1'b0);
        mmio <= 1'b0;
        dq(3'b001, 64'h0001_0020_0000, 1'b1);
        dq(3'b001, 64'h0001_0050_0000, 1'b0);
        dq(3'b101, 64'h0001_0050_0000, 1'b1);
        dq(3'b101, 64'h0001_0020_0000, 1'b0);
        cfg_wr(PFW_OFF_BASE_HI, 32'h0000_0000);
        dq(3'b001, 64'h0010_0000, 1'b1);
        dq(3'b001, 64'h000F_FFFF, 1'b0);
        dq(3'b101, 64'h000F_FFFF, 1'b1);
        dq(3'b001, 64'h0001_003F_FFFF, 1'b1);
        dq(3'b101, 64'h0001_003F_FFFF, 1'b0);
        dq(3'b101, 64'h0001_0040_0000, 1'b1);
        // equal high words, low base above low limit: window off
        cfg_wr(PFW_OFF_BASE_HI, 32'h0000_0001);
        cfg_wr(PFW_OFF_BASE_LIMIT, 32'h0030_0050);
        dq(3'b001, 64'h0001_0040_0000, 1'b0);
        chk("win off", dec.win_off, 1'b1);
        $display("test dual done");
        io_en <= 1'b1;
        vga <= 1'b1;
        snp <= 1'b1;
        dq(3'b000, 64'h000A_0000, 1'b1);
        chk("one phase", dec.single_phase, 1'b1);
        dq(3'b001, 64'h000B_FFFF, 1'b1);
        dq(3'b101, 64'h000A_0000, 1'b0);
        dq(3'b111, 64'h0000_03B0, 1'b0);
        dq(3'b001, 64'h000C_0000, 1'b0);
        dq(3'b011, 64'h0000_03B0, 1'b1);
        dq(3'b011, 64'h0000_03BB, 1'b1);
        dq(3'b011, 64'h0000_03BC, 1'b0);
        dq(3'b011, 64'h0000_FFDF, 1'b1);
        dq(3'b011, 64'h0001_03C0, 1'b0);
        dq(3'b011, 64'h0000_03C6, 1'b1);
        chk("snoop", dec.snoop, 1'b0);
        $display("test display done");
        vga <= 1'b0;
        foreach (pal[n])
        begin
            dq(3'b011, pal[n], 1'b1);
            chk("snoop", dec.snoop, 1'b1);
        end
        dq(3'b011, 64'h0000_03C7, 1'b0);
        dq(3'b010, 64'h0000_03C8, 1'b0);
        $display("test snoop done");
        stop_test();
    end
endmodule // tb
